// *** core/bau_pkg.sv ***
// constants and types shared by the binary arithmetic unit
// assumes a single 20 MHz clock domain and plain-port control
//
// What this block does
// - divide dividend by divisor: quotient R, remainder R+1
// - zero divisor raises the fault flag
// - divide sets zero flag on zero result
// - divide treats both operands as unsigned
// - double add sums two pairs plus carry
// - double add carry when sum exceeds FFFFFFFF
// - signed overflow and underflow flags on add/subtract
// - overflow at bit 25404, underflow at 25405
// - carry flag lives at status bit 25504
// - false condition leaves results untouched
// - double subtract takes amount and carry from base
// - negative difference sets carry, stores two's complement
// - carry exactly when base below amount plus carry
// - add/subtract set zero flag on zero result
// - signed 16x16 multiply, product low in R
// - multiply zero flag follows 32-bit product
// - signed 32x32 multiply, 64-bit product R..R+3
// - double multiply zero only when all words zero
// - invalid indirect operand raises the fault flag
package bau_pkg;
	localparam int WORD_W = 16;
	localparam int OP_W = 3;
	// status bit numbers of the flag word
	localparam int OVERFLOW_BIT_NUM = 25404;
	localparam int UNDERFLOW_BIT_NUM = 25405;
	localparam int CARRY_BIT_NUM = 25504;
	localparam int DIV_STEPS = 16;
	localparam int MUL_STEPS = 32;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [31:0] MAX_U32 = 32'hFFFFFFFF;

	typedef enum logic [2:0] {
		BAU_OP_UDIV = 3'h0,
		BAU_OP_DADD = 3'h1,
		BAU_OP_DSUB = 3'h2,
		BAU_OP_SMUL = 3'h3,
		BAU_OP_DSMUL = 3'h4
	} bau_op_t;
endpackage

// *** core/bau_udiv.sv ***
// unsigned restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse from the same clock
`timescale 1ns/100ps
`default_nettype none
module bau_udiv #(
	parameter int WIDTH = 16
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire logic [WIDTH-1:0] dividend_in,
	input wire logic [WIDTH-1:0] divisor_in,
	output logic [WIDTH-1:0] quotient_out,
	output logic [WIDTH-1:0] remainder_out,
	output logic done_out
);
	logic [WIDTH-1:0] quot_reg;
	logic [WIDTH:0] rem_reg;
	logic [WIDTH-1:0] dsr_reg;
	logic [$clog2(WIDTH+1)-1:0] count_reg;
	logic busy_reg;
	logic [WIDTH:0] trial_next;
	logic [WIDTH:0] sub_next;

	// shift next dividend bit into the partial remainder and try subtracting
	always_comb begin
		trial_next = {rem_reg[WIDTH-1:0], quot_reg[WIDTH-1]};
		sub_next = trial_next - {1'b0, dsr_reg};
	end

	// both operands zero-extended, so no sign ever enters
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			quot_reg <= '0;
			rem_reg <= '0;
			dsr_reg <= '0;
			count_reg <= '0;
			busy_reg <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				quot_reg <= dividend_in;
				rem_reg <= '0;
				dsr_reg <= divisor_in;
				count_reg <= ($clog2(WIDTH+1))'(WIDTH);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (!sub_next[WIDTH]) begin
					rem_reg <= sub_next;
					quot_reg <= {quot_reg[WIDTH-2:0], 1'b1};
				end else begin
					rem_reg <= trial_next;
					quot_reg <= {quot_reg[WIDTH-2:0], 1'b0};
				end
				count_reg <= count_reg - 1'b1;
				if (count_reg == 1) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end

	assign quotient_out = quot_reg;
	assign remainder_out = rem_reg[WIDTH-1:0];
endmodule // bau_udiv
`default_nettype wire

// *** core/bau_smul.sv ***
// signed shift-add multiplier, one multiplier bit per clock
// assumes start is a one-cycle pulse; narrow operands arrive sign-extended
`timescale 1ns/100ps
`default_nettype none
module bau_smul #(
	parameter int WIDTH = 32
) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire logic [WIDTH-1:0] mcand_in,
	input wire logic [WIDTH-1:0] mplier_in,
	output logic [2*WIDTH-1:0] product_out,
	output logic done_out
);
	logic [2*WIDTH-1:0] acc_reg;
	logic [2*WIDTH-1:0] mcand_reg;
	logic [WIDTH-1:0] mplier_reg;
	logic [$clog2(WIDTH+1)-1:0] count_reg;
	logic busy_reg;

	// top multiplier bit has negative weight, so it subtracts
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acc_reg <= '0;
			mcand_reg <= '0;
			mplier_reg <= '0;
			count_reg <= '0;
			busy_reg <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				acc_reg <= '0;
				mcand_reg <= {{WIDTH{mcand_in[WIDTH-1]}}, mcand_in};
				mplier_reg <= mplier_in;
				count_reg <= ($clog2(WIDTH+1))'(WIDTH);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (mplier_reg[0]) begin
					if (count_reg == 1)
						acc_reg <= acc_reg - mcand_reg;
					else
						acc_reg <= acc_reg + mcand_reg;
				end
				mcand_reg <= {mcand_reg[2*WIDTH-2:0], 1'b0};
				mplier_reg <= {1'b0, mplier_reg[WIDTH-1:1]};
				count_reg <= count_reg - 1'b1;
				if (count_reg == 1) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end

	assign product_out = acc_reg;
endmodule // bau_smul
`default_nettype wire

// *** core/bau_unit.sv ***
// binary arithmetic unit: divide, double add/subtract, signed multiplies
// assumes the sequencer holds operands steady only in the start cycle
`timescale 1ns/100ps
`default_nettype none
module bau_unit (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire logic exec_cond_in,
	input wire bau_pkg::bau_op_t op_in,
	input wire logic [15:0] operand_a0_in,
	input wire logic [15:0] operand_a1_in,
	input wire logic [15:0] operand_b0_in,
	input wire logic [15:0] operand_b1_in,
	input wire logic indirect_bad_in,
	input wire logic clear_carry_in,
	output logic [15:0] result_r0_out,
	output logic [15:0] result_r1_out,
	output logic [15:0] result_r2_out,
	output logic [15:0] result_r3_out,
	output logic [3:0] result_valid_out,
	output logic carry_flag_out,
	output logic zero_result_flag_out,
	output logic overflow_flag_out,
	output logic underflow_flag_out,
	output logic fault_flag_out,
	output logic busy_out,
	output logic done_out
);
	import bau_pkg::*;

	typedef enum logic [1:0] {
		BAU_IDLE,
		BAU_DIV,
		BAU_MUL
	} bau_state_t;

	bau_state_t state_reg;
	bau_op_t op_reg;
	logic div_start;
	logic mul_start;
	logic div_done;
	logic mul_done;
	logic [15:0] div_quot;
	logic [15:0] div_rem;
	logic [63:0] mul_prod;
	logic [31:0] mul_a;
	logic [31:0] mul_b;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [32:0] add_sum;
	logic [32:0] sub_diff;
	logic add_ovf;
	logic add_unf;
	logic sub_ovf;
	logic sub_unf;
	logic go;
	logic direct_done;

	////////////////////////////////////////////////////////////////////
	// operand assembly and single-cycle add/subtract

	assign opa = {operand_a1_in, operand_a0_in};
	assign opb = {operand_b1_in, operand_b0_in};
	// an invalid indirect operand aborts without touching results
	assign go = start_in && exec_cond_in && !indirect_bad_in && (state_reg == BAU_IDLE);

	// 33-bit sums keep the carry out; borrow is bit 32 of the difference
	always_comb begin
		add_sum = {1'b0, opa} + {1'b0, opb} + {32'h0, carry_flag_out};
		sub_diff = {1'b0, opa} - {1'b0, opb} - {32'h0, carry_flag_out};
		add_ovf = !opa[31] && !opb[31] && add_sum[31];
		add_unf = opa[31] && opb[31] && !add_sum[31];
		sub_ovf = !opa[31] && opb[31] && sub_diff[31];
		sub_unf = opa[31] && !opb[31] && !sub_diff[31];
	end

	// narrow multiply sign-extends into the wide engine
	always_comb begin
		if (op_in == BAU_OP_SMUL) begin
			mul_a = {{16{operand_a0_in[15]}}, operand_a0_in};
			mul_b = {{16{operand_b0_in[15]}}, operand_b0_in};
		end else begin
			mul_a = opa;
			mul_b = opb;
		end
	end

	assign div_start = go && op_in == BAU_OP_UDIV && operand_b0_in != ZERO_WORD;
	assign mul_start = go && (op_in == BAU_OP_SMUL || op_in == BAU_OP_DSMUL);
	assign direct_done = start_in && (state_reg == BAU_IDLE) && !div_start && !mul_start;

	bau_udiv #(
		.WIDTH(WORD_W)
	) u_udiv (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.start_in(div_start),
		.dividend_in(operand_a0_in),
		.divisor_in(operand_b0_in),
		.quotient_out(div_quot),
		.remainder_out(div_rem),
		.done_out(div_done)
	);

	bau_smul #(
		.WIDTH(2*WORD_W)
	) u_smul (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.start_in(mul_start),
		.mcand_in(mul_a),
		.mplier_in(mul_b),
		.product_out(mul_prod),
		.done_out(mul_done)
	);

	////////////////////////////////////////////////////////////////////
	// sequencing of multi-cycle operations

	// new starts while busy are ignored; sequencer waits for done
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= BAU_IDLE;
			op_reg <= BAU_OP_UDIV;
		end else begin
			case (state_reg)
				BAU_IDLE: begin
					if (div_start) begin
						state_reg <= BAU_DIV;
					end else if (mul_start) begin
						state_reg <= BAU_MUL;
					end
					if (start_in)
						op_reg <= op_in;
				end
				BAU_DIV: begin
					if (div_done)
						state_reg <= BAU_IDLE;
				end
				BAU_MUL: begin
					if (mul_done)
						state_reg <= BAU_IDLE;
				end
				default: state_reg <= BAU_IDLE;
			endcase
		end
	end

	assign busy_out = (state_reg != BAU_IDLE);

	// done pulse marks valid results and flags, also for skipped ops
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			done_out <= 1'b0;
		else
			done_out <= direct_done || (state_reg == BAU_DIV && div_done)
				|| (state_reg == BAU_MUL && mul_done);
	end

	////////////////////////////////////////////////////////////////////
	// result words

	// false condition writes nothing and marks no word
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			result_r0_out <= 16'h0000;
			result_r1_out <= 16'h0000;
			result_r2_out <= 16'h0000;
			result_r3_out <= 16'h0000;
			result_valid_out <= 4'h0;
		end else if (direct_done) begin
			result_valid_out <= 4'h0;
			if (go && op_in == BAU_OP_DADD) begin
				{result_r1_out, result_r0_out} <= add_sum[31:0];
				result_valid_out <= 4'h3;
			end else if (go && op_in == BAU_OP_DSUB) begin
				// wraparound difference is already two's complement
				{result_r1_out, result_r0_out} <= sub_diff[31:0];
				result_valid_out <= 4'h3;
			end
		end else if (state_reg == BAU_DIV && div_done) begin
			result_r0_out <= div_quot;
			result_r1_out <= div_rem;
			result_valid_out <= 4'h3;
		end else if (state_reg == BAU_MUL && mul_done) begin
			result_r0_out <= mul_prod[15:0];
			result_r1_out <= mul_prod[31:16];
			if (op_reg == BAU_OP_DSMUL) begin
				result_r2_out <= mul_prod[47:32];
				result_r3_out <= mul_prod[63:48];
				result_valid_out <= 4'hF;
			end else begin
				result_valid_out <= 4'h3;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags: carry, overflow, underflow, zero, fault

	// carry at its status bit; a clear request loses to an executing add or subtract
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			carry_flag_out <= 1'b0;
		else if (go && op_in == BAU_OP_DADD)
			carry_flag_out <= add_sum[32];
		else if (go && op_in == BAU_OP_DSUB)
			carry_flag_out <= sub_diff[32];
		else if (clear_carry_in)
			carry_flag_out <= 1'b0;
	end

	// signed range flags mapped to their status bits
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			overflow_flag_out <= 1'b0;
			underflow_flag_out <= 1'b0;
		end else if (go && op_in == BAU_OP_DADD) begin
			overflow_flag_out <= add_ovf;
			underflow_flag_out <= add_unf;
		end else if (go && op_in == BAU_OP_DSUB) begin
			overflow_flag_out <= sub_ovf;
			underflow_flag_out <= sub_unf;
		end
	end

	// zero flag follows whichever result completes
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			zero_result_flag_out <= 1'b0;
		else if (go && op_in == BAU_OP_DADD)
			zero_result_flag_out <= (add_sum[31:0] == 32'h0);
		else if (go && op_in == BAU_OP_DSUB)
			zero_result_flag_out <= (sub_diff[31:0] == 32'h0);
		else if (state_reg == BAU_DIV && div_done)
			zero_result_flag_out <= (div_quot == ZERO_WORD);
		else if (state_reg == BAU_MUL && mul_done) begin
			if (op_reg == BAU_OP_DSMUL)
				zero_result_flag_out <= (mul_prod == 64'h0);
			else
				zero_result_flag_out <= (mul_prod[31:0] == 32'h0);
		end
	end

	// fault refreshes on every taken start; divisor zero or bad pointer
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			fault_flag_out <= 1'b0;
		else if (start_in && state_reg == BAU_IDLE && exec_cond_in)
			fault_flag_out <= indirect_bad_in
				|| (op_in == BAU_OP_UDIV && operand_b0_in == ZERO_WORD);
	end

	////////////////////////////////////////////////////////////////////
	// checks

	a_done_after_div: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		div_start |-> ##18 done_out)
		else $error("divide done not 18 cycles after start");

	a_div_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		div_start |-> ##18 ((32'(result_r0_out) * 32'($past(operand_b0_in, 18))
			+ 32'(result_r1_out) == 32'($past(operand_a0_in, 18)))
			&& result_r1_out < $past(operand_b0_in, 18)))
		else $error("divide quotient or remainder wrong");

	a_div_zero_fault: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(go && op_in == BAU_OP_UDIV && operand_b0_in == ZERO_WORD)
			|=> fault_flag_out && done_out)
		else $error("zero divisor did not raise fault");

	a_add_carry_out: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(go && op_in == BAU_OP_DADD) |=> carry_flag_out ==
			(({1'b0, $past(opa)} + {1'b0, $past(opb)} + {32'h0, $past(carry_flag_out)})
			> {1'b0, MAX_U32}))
		else $error("add carry wrong");

	a_sub_borrow: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(go && op_in == BAU_OP_DSUB) |=> carry_flag_out ==
			({1'b0, $past(opa)} < {1'b0, $past(opb)} + {32'h0, $past(carry_flag_out)}))
		else $error("subtract borrow wrong");

	a_sub_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(go && op_in == BAU_OP_DSUB) |=> {result_r1_out, result_r0_out} ==
			32'($past(opa) - $past(opb) - {31'h0, $past(carry_flag_out)}))
		else $error("subtract result wrong");

	a_addsub_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(go && (op_in == BAU_OP_DADD || op_in == BAU_OP_DSUB))
			|=> zero_result_flag_out == ({result_r1_out, result_r0_out} == 32'h0))
		else $error("add or subtract zero flag wrong");

	a_skip_keeps_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(start_in && !exec_cond_in && state_reg == BAU_IDLE)
			|=> $stable(result_r0_out) && $stable(result_r1_out) && result_valid_out == 4'h0)
		else $error("skipped op changed results");

	a_add_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(go && op_in == BAU_OP_DADD) |=> {result_r1_out, result_r0_out} ==
			32'($past(opa) + $past(opb) + {31'h0, $past(carry_flag_out)}))
		else $error("add result wrong");

	a_bad_ptr_fault: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(start_in && exec_cond_in && indirect_bad_in && state_reg == BAU_IDLE)
			|=> fault_flag_out && result_valid_out == 4'h0)
		else $error("invalid operand did not fault");

	a_carry_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(clear_carry_in && !(go && (op_in == BAU_OP_DADD || op_in == BAU_OP_DSUB)))
			|=> !carry_flag_out)
		else $error("carry clear request ignored");

	a_smul_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(mul_start && op_in == BAU_OP_SMUL) |-> ##34 {result_r1_out, result_r0_out} ==
			32'($signed($past(operand_a0_in, 34))) * 32'($signed($past(operand_b0_in, 34))))
		else $error("signed multiply product wrong");

	a_dsmul_result: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(mul_start && op_in == BAU_OP_DSMUL) |-> ##34
			{result_r3_out, result_r2_out, result_r1_out, result_r0_out} ==
			64'($signed({$past(operand_a1_in, 34), $past(operand_a0_in, 34)}))
			* 64'($signed({$past(operand_b1_in, 34), $past(operand_b0_in, 34)})))
		else $error("double multiply product wrong");

	a_mul_zero_flag: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(state_reg == BAU_MUL && mul_done && op_reg == BAU_OP_DSMUL)
			|=> zero_result_flag_out == ({result_r3_out, result_r2_out,
				result_r1_out, result_r0_out} == 64'h0))
		else $error("double multiply zero flag wrong");

	a_mul_latency: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		mul_start |=> busy_out ##33 done_out)
		else $error("multiply done not 34 cycles after start");

	c_div_run: cover property (@(posedge clock_in) disable iff (!reset_n_in) div_start ##18 done_out);
	c_sub_neg: cover property (@(posedge clock_in) disable iff (!reset_n_in)
		go && op_in == BAU_OP_DSUB && sub_diff[32]);
	c_dmul_run: cover property (@(posedge clock_in) disable iff (!reset_n_in)
		state_reg == BAU_MUL && mul_done && op_reg == BAU_OP_DSMUL);
	c_add_ovf: cover property (@(posedge clock_in) disable iff (!reset_n_in)
		go && op_in == BAU_OP_DADD && add_ovf);
endmodule // bau_unit
`default_nettype wire

// *** verification/bau_seq_model.sv ***
// sequencer model: issues one instruction at a time, then waits for done
// assumes the unit answers within 40 cycles and samples inputs on the rising edge
`timescale 1ns/100ps
`default_nettype none
module bau_seq_model (
	input wire logic clock_in,
	input wire logic done_in,
	output logic start_out,
	output logic exec_cond_out,
	output bau_pkg::bau_op_t op_out,
	output logic [15:0] a0_out,
	output logic [15:0] a1_out,
	output logic [15:0] b0_out,
	output logic [15:0] b1_out,
	output logic indirect_bad_out,
	output logic clear_carry_out
);
	import bau_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// idle levels before the first request
	initial begin
		{start_out, exec_cond_out, indirect_bad_out, clear_carry_out} = 4'h0;
		op_out = BAU_OP_UDIV;
		{a1_out, a0_out, b1_out, b0_out} = 64'h0;
	end

	// one request; inj pokes a second start while the unit is busy
	task automatic issue(input bau_op_t o, input logic c, input logic [31:0] a,
			input logic [31:0] b, input logic bad, input logic inj, output int lat);
		@(posedge clock_in);
		start_out <= 1'b1;
		exec_cond_out <= c;
		op_out <= o;
		{a1_out, a0_out} <= a; // whole pairs in one go
		{b1_out, b0_out} <= b;
		indirect_bad_out <= bad;
		@(posedge clock_in);
		start_out <= 1'b0;
		// stale operands are inverted so a late sample never matches
		{a1_out, a0_out} <= ~a;
		{b1_out, b0_out} <= ~b;
		lat = 0;
		for (int n = 1; n <= 40; n++) begin
			@(negedge clock_in);
			if (done_in === 1'b1) begin
				lat = n;
				break;
			end
			@(posedge clock_in);
			start_out <= inj && (n == 3);
			if (inj && (n == 3)) begin
				op_out <= BAU_OP_DADD;
			end
		end
	endtask

	// one-cycle carry clear while the unit is idle
	task automatic clear_carry();
		@(posedge clock_in);
		clear_carry_out <= 1'b1;
		@(posedge clock_in);
		clear_carry_out <= 1'b0;
	endtask
endmodule // bau_seq_model
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the binary arithmetic unit
// assumes the sequencer model drives every unit input except clock and reset
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import bau_pkg::*;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic start, cond, bad, clr, busy, done, cy, zr, ov, un, ft;
	bau_op_t op;
	logic [15:0] a0, a1, b0, b1, r0, r1, r2, r3;
	logic [3:0] valid;
	logic [63:0] exp_r;
	logic [3:0] exp_v;
	logic exp_cy, exp_zr, exp_ov, exp_un, exp_ft;
	int fails = 0;
	int checked = 0;

	////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	always #25 clock_in = ~clock_in;

	bau_seq_model seq_model (.clock_in(clock_in), .done_in(done), .start_out(start),
		.exec_cond_out(cond), .op_out(op), .a0_out(a0), .a1_out(a1), .b0_out(b0),
		.b1_out(b1), .indirect_bad_out(bad), .clear_carry_out(clr));
	bau_unit DUT (.clock_in(clock_in), .reset_n_in(reset_n_in), .start_in(start),
		.exec_cond_in(cond), .op_in(op), .operand_a0_in(a0), .operand_a1_in(a1),
		.operand_b0_in(b0), .operand_b1_in(b1), .indirect_bad_in(bad),
		.clear_carry_in(clr), .result_r0_out(r0), .result_r1_out(r1),
		.result_r2_out(r2), .result_r3_out(r3), .result_valid_out(valid),
		.carry_flag_out(cy), .zero_result_flag_out(zr), .overflow_flag_out(ov),
		.underflow_flag_out(un), .fault_flag_out(ft), .busy_out(busy), .done_out(done));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] expv);
		checked++;
		if (seen !== expv) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, expv, seen);
		end
	endtask

	// reference arithmetic; flags not touched by an op keep their value
	task automatic predict(input bau_op_t o, input logic c, input logic [31:0] a,
			input logic [31:0] b, input logic bad);
		logic [32:0] w;
		longint sv;
		exp_v = 4'h0;
		if (!c) return;
		exp_ft = bad || (o == BAU_OP_UDIV && b[15:0] == 16'h0000);
		if (exp_ft) return;
		case (o)
			BAU_OP_UDIV: begin
				exp_r[31:0] = {a[15:0] % b[15:0], a[15:0] / b[15:0]};
				exp_zr = (a[15:0] / b[15:0]) == 16'h0000;
				exp_v = 4'h3;
			end
			BAU_OP_DADD, BAU_OP_DSUB: begin
				if (o == BAU_OP_DADD) begin
					w = {1'b0, a} + {1'b0, b} + {32'h0, exp_cy};
					sv = longint'($signed(a)) + longint'($signed(b)) + longint'(exp_cy);
					exp_cy = w[32];
				end else begin
					w = {1'b0, a} - {1'b0, b} - {32'h0, exp_cy};
					sv = longint'($signed(a)) - longint'($signed(b)) - longint'(exp_cy);
					exp_cy = {1'b0, a} < ({1'b0, b} + {32'h0, exp_cy});
				end
				exp_r[31:0] = w[31:0];
				exp_zr = w[31:0] == 32'h0;
				exp_ov = sv > 64'sh7FFFFFFF;
				exp_un = sv < -64'sh80000000;
				exp_v = 4'h3;
			end
			BAU_OP_SMUL: begin
				sv = longint'($signed(a[15:0])) * longint'($signed(b[15:0]));
				exp_r[31:0] = sv[31:0];
				exp_zr = sv[31:0] == 32'h0;
				exp_v = 4'h3;
			end
			default: begin
				sv = longint'($signed(a)) * longint'($signed(b));
				exp_r = sv;
				exp_zr = sv == 0;
				exp_v = 4'hF;
			end
		endcase
	endtask

	// issue one instruction and compare everything the unit shows
	task automatic run(input bau_op_t o, input logic c, input logic [31:0] a,
			input logic [31:0] b, input logic bad, input logic inj);
		int lat;
		int want;
		want = 1;
		if (c && !bad && o == BAU_OP_UDIV && b[15:0] != 16'h0000) want = 18;
		if (c && !bad && (o == BAU_OP_SMUL || o == BAU_OP_DSMUL)) want = 34;
		predict(o, c, a, b, bad);
		seq_model.issue(o, c, a, b, bad, inj, lat);
		check("latency", 64'(lat), 64'(want));
		check("results", {r3, r2, r1, r0}, exp_r);
		check("valid", 64'(valid), 64'(exp_v));
		check("flags", 64'({cy, zr, ov, un, ft}),
			64'({exp_cy, exp_zr, exp_ov, exp_un, exp_ft}));
		check("busy", 64'(busy), 64'h0);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: about 60 instructions of at most 35 cycles, wide margin
	initial begin
		repeat (20000) @(posedge clock_in);
		fails++;
		wrap_up();
	end

	// corner cases first, then a random stream
	initial begin
		bau_op_t o;
		exp_r = 64'h0;
		exp_v = 4'h0;
		{exp_cy, exp_zr, exp_ov, exp_un, exp_ft} = 5'h00;
		repeat (12) @(posedge clock_in);
		reset_n_in <= 1'b1;
		void'($urandom(24));
		@(negedge clock_in);
		check("reset results", {r3, r2, r1, r0}, 64'h0);
		check("reset flags", 64'({valid, cy, zr, ov, un, ft, busy, done}), 64'h0);
		run(BAU_OP_DADD, 1'b1, 32'h7FFFFFFF, 32'h00000001, 1'b0, 1'b0);
		run(BAU_OP_DADD, 1'b1, 32'h80000000, 32'hFFFFFFFF, 1'b0, 1'b0);
		run(BAU_OP_DADD, 1'b1, 32'hFFFFFFFE, 32'h00000000, 1'b0, 1'b0);
		run(BAU_OP_DADD, 1'b1, 32'hFFFFFFFF, 32'h00000001, 1'b0, 1'b0);
		run(BAU_OP_DSUB, 1'b1, 32'h00000000, 32'h00000000, 1'b0, 1'b0);
		run(BAU_OP_DSUB, 1'b1, 32'h00000005, 32'h00000004, 1'b0, 1'b0);
		run(BAU_OP_DSUB, 1'b1, 32'h80000000, 32'h00000001, 1'b0, 1'b0);
		run(BAU_OP_DSUB, 1'b1, 32'h7FFFFFFF, 32'hFFFFFFFF, 1'b0, 1'b0);
		seq_model.clear_carry();
		@(negedge clock_in);
		exp_cy = 1'b0;
		check("carry clear", 64'(cy), 64'h0);
		run(BAU_OP_DADD, 1'b0, 32'h12345678, 32'h11111111, 1'b0, 1'b0);
		run(BAU_OP_DADD, 1'b1, 32'h12345678, 32'h11111111, 1'b1, 1'b0);
		run(BAU_OP_UDIV, 1'b1, 32'h0000FFFF, 32'h00000001, 1'b0, 1'b0);
		run(BAU_OP_UDIV, 1'b1, 32'h00000005, 32'h00000007, 1'b0, 1'b0);
		run(BAU_OP_UDIV, 1'b1, 32'h00001234, 32'h00000000, 1'b0, 1'b0);
		run(BAU_OP_UDIV, 1'b1, 32'h0000F00D, 32'h0000800F, 1'b0, 1'b1);
		run(BAU_OP_SMUL, 1'b1, 32'h00008000, 32'h00008000, 1'b0, 1'b0);
		run(BAU_OP_SMUL, 1'b1, 32'h0000FFFF, 32'h00000001, 1'b0, 1'b0);
		run(BAU_OP_SMUL, 1'b1, 32'h00000000, 32'h00007FFF, 1'b0, 1'b0);
		run(BAU_OP_DSMUL, 1'b1, 32'h80000000, 32'h80000000, 1'b0, 1'b0);
		run(BAU_OP_DSMUL, 1'b1, 32'hFFFFFFFF, 32'h00000001, 1'b0, 1'b0);
		run(BAU_OP_DSMUL, 1'b1, 32'h00000000, 32'hFFFFFFFF, 1'b0, 1'b0);
		run(BAU_OP_DSMUL, 1'b1, 32'h00010000, 32'h00010000, 1'b1, 1'b0);
		for (int i = 0; i < 40; i++) begin
			o = bau_op_t'($urandom_range(4, 0));
			run(o, $urandom_range(7, 0) != 0, $urandom,
				($urandom_range(7, 0) == 0) ? 32'h0 : $urandom,
				$urandom_range(15, 0) == 0, 1'b0);
		end
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
